// ===== logic/usb_sie_event_status.v
`include "sie_event_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module usb_sie_event_status #(
	parameter FS_CYCLES = `IDLE_FS_CYCLES,
	parameter SUSP_CYCLES = `IDLE_SUSP_CYCLES
) (
	input wire clk_in,
	input wire rst_in,
	input wire [15:0] addr_in,
	input wire wr_in,
	input wire [7:0] wdata_in,
	output reg [7:0] rdata_out,
	input wire core_reset_in,
	input wire [7:0] bus_event_mask_in,
	output wire top_status_0_out,
	input wire halt_clear_req_in,
	input wire set_config_req_in,
	input wire [3:0] config_value_in,
	input wire interface_set_flag_req_in,
	input wire setup_in,
	input wire bus_idle_in,
	output wire full_speed_out,
	output wire [7:0] source_irq_out,
	output reg ep0_disable_out,
	output reg ctrl_out_buffer_flush_out,
	output reg ctrl_in_buffer_flush_out,
	output reg [1:0] endpoint_flush_flag_out,
	input wire [3:0] ep_out_event_in,
	input wire [3:0] ep_in_event_in,
	output wire [7:0] ep_irq_out,
	input wire [4:0] fifo_level_in,
	input wire buf_last_in,
	input wire [15:0] buf_len_in,
	output wire prefetch_go_out
);
	// ========================================
	// Register writes
	reg [3:0] prefetch_level;
	reg [3:0] config_value;
	reg core_reset_d;
	reg setup_redo;
	wire bus_reset_flag;
	wire [6:2] src;
	wire suspend_pulse;
	wire wr_stat = wr_in && addr_in == `ADDR_BUS_STATUS;
	wire wr_src = wr_in && addr_in == `ADDR_SOURCE;
	always @(posedge clk_in) begin
		if (rst_in) begin
			prefetch_level <= `PREFETCH_RESET;
			config_value <= 4'h0;
			core_reset_d <= 1'b0;
			setup_redo <= 1'b0;
			ep0_disable_out <= 1'b0;
			ctrl_out_buffer_flush_out <= 1'b0;
			ctrl_in_buffer_flush_out <= 1'b0;
			endpoint_flush_flag_out <= 2'h0;
		end else begin
			if (wr_in && addr_in == `ADDR_PREFETCH)
				prefetch_level <= wdata_in[3:0];
			if (set_config_req_in)
				config_value <= config_value_in;
			core_reset_d <= core_reset_in;
			// Repeat SETUP while flag is high: drop for one cycle, then set again
			setup_redo <= setup_in && src[`BIT_SETUP];
			ctrl_out_buffer_flush_out <= setup_in;
			ctrl_in_buffer_flush_out <= setup_in;
			if (setup_in) begin
				ep0_disable_out <= 1'b1;
				endpoint_flush_flag_out <= 2'h3;
			end else if (wr_src && wdata_in[`BIT_SETUP]) begin
				// Software re-enables endpoint 0 by acknowledging the setup
				ep0_disable_out <= 1'b0;
				endpoint_flush_flag_out <= 2'h0;
			end
		end
	end
	// ========================================
	// Flags
	w1c_flag u_bus_reset (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.set_in(core_reset_d && !core_reset_in),
		.clear_in(wr_stat && wdata_in[`BIT_BUS_RESET]),
		.flag_out(bus_reset_flag)
	);
	assign top_status_0_out = bus_reset_flag & bus_event_mask_in[`BIT_BUS_RESET];
	wire [6:2] src_set;
	wire [6:2] src_clr;
	assign src_set[`BIT_HALT_CLR] = halt_clear_req_in;
	assign src_set[`BIT_CONFIG_SET] = set_config_req_in;
	assign src_set[`BIT_SUSPEND] = suspend_pulse;
	assign src_set[`BIT_INTF_SET] = interface_set_flag_req_in;
	assign src_set[`BIT_SETUP] = (setup_in && !src[`BIT_SETUP]) || setup_redo;
	assign src_clr = wdata_in[6:2] & {5{wr_src}};
	wire [6:2] src_clr_eff = src_clr | {4'h0, setup_in && src[`BIT_SETUP]};
	genvar i;
	generate
		for (i = 2; i <= 6; i = i + 1) begin : g_src
			w1c_flag u_flag (
				.clk_in(clk_in),
				.rst_in(rst_in),
				.set_in(src_set[i]),
				.clear_in(src_clr_eff[i]),
				.flag_out(src[i])
			);
		end
	endgenerate
	assign source_irq_out = {1'b0, src, 2'h0};
	idle_timer #(
		.FS_CYCLES(FS_CYCLES),
		.SUSP_CYCLES(SUSP_CYCLES)
	) u_idle (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.idle_in(bus_idle_in),
		.full_speed_out(full_speed_out),
		.suspend_pulse_out(suspend_pulse)
	);
	// ========================================
	// Endpoint summaries, read-only
	wire [7:0] ep_sum = {ep_out_event_in[3], ep_in_event_in[3], ep_out_event_in[2], ep_in_event_in[2],
		ep_out_event_in[1], ep_in_event_in[1], ep_out_event_in[0], ep_in_event_in[0]};
	assign ep_irq_out = ep_sum;
	// ========================================
	// Prefetch trigger
	assign prefetch_go_out = (fifo_level_in >= {1'b0, prefetch_level} + 5'h01) ||
		(buf_last_in && buf_len_in < {10'h000, prefetch_level, 2'h0});
	// ========================================
	// Read data, registered
	always @(posedge clk_in) begin
		if (rst_in)
			rdata_out <= 8'h00;
		else begin
			case (addr_in)
				`ADDR_PREFETCH: rdata_out <= {4'h0, prefetch_level};
				`ADDR_BUS_STATUS: rdata_out <= {7'h00, bus_reset_flag};
				`ADDR_SOURCE: rdata_out <= {1'b0, src, 2'h0};
				`ADDR_EP_SUMMARY: rdata_out <= ep_sum;
				`ADDR_CONFIG: rdata_out <= {4'h0, config_value};
				default: rdata_out <= 8'h00;
			endcase
		end
	end
endmodule // usb_sie_event_status
`default_nettype wire

// ===== logic/sie_event_defs.vh
// Function
// - Prefetch level in bits 3:0, words; trigger when buffered level reaches level plus one.
// - Prefetch level resets to 3, a four-word (16-byte) trigger.
// - A last-flagged buffer shorter than the level proceeds without waiting.
// - Bus-reset flag sets when the core's reset indication is removed.
// - Bus status flags clear only on a written one.
// - Unmasked bus status flags OR into one summary bit for top status 0.
// - Each source flag drives its own interrupt line; no masking here.
// - Source bit 6 sets on clear-feature endpoint-halt on any endpoint.
// - Source bit 5 sets when SET_CONFIGURATION is stored and readable.
// - After 3 ms idle drop to full speed, then 2 ms later set bit 4.
// - Source bit 2 sets on SETUP; a repeat SETUP drops it one cycle then resets it.
// - SETUP disables endpoint, flushes both endpoint 0 buffers, sets their flush flags.
// - Endpoint summary bits 7..0 are write/read summaries of endpoints 3..0.
// - Endpoint summary bits are read-only; cleared by clearing the endpoint event.
// - Each summary bit drives its endpoint interrupt line; endpoint 3 to aggregate group.
// - Stored configuration value, four bits, is the last one set by the host.
`ifndef SIE_EVENT_DEFS_VH
`define SIE_EVENT_DEFS_VH
`define ADDR_PREFETCH 16'h2C03
`define ADDR_BUS_STATUS 16'h2C08
`define ADDR_SOURCE 16'h2C0A
`define ADDR_EP_SUMMARY 16'h2C0C
`define ADDR_CONFIG 16'h2C01
`define PREFETCH_RESET 4'h3
`define BIT_BUS_RESET 0
`define BIT_HALT_CLR 6
`define BIT_CONFIG_SET 5
`define BIT_SUSPEND 4
`define BIT_INTF_SET 3
`define BIT_SETUP 2
`define CLK_MHZ 50
`define IDLE_FS_US 3000
`define IDLE_SUSP_US 2000
`define IDLE_FS_CYCLES (`IDLE_FS_US * `CLK_MHZ)
`define IDLE_SUSP_CYCLES (`IDLE_SUSP_US * `CLK_MHZ)
`endif

// ===== logic/w1c_flag.v
`timescale 1ns/10ps
`default_nettype none
module w1c_flag (
	input wire clk_in,
	input wire rst_in,
	input wire set_in,
	input wire clear_in,
	output reg flag_out
);
	always @(posedge clk_in) begin
		if (rst_in)
			flag_out <= 1'b0;
		else if (set_in)
			flag_out <= 1'b1;
		else if (clear_in)
			flag_out <= 1'b0;
	end
endmodule // w1c_flag
`default_nettype wire

// ===== logic/idle_timer.v
`timescale 1ns/10ps
`default_nettype none
module idle_timer #(
	parameter FS_CYCLES = 150000,
	parameter SUSP_CYCLES = 100000
) (
	input wire clk_in,
	input wire rst_in,
	input wire idle_in,
	output reg full_speed_out,
	output reg suspend_pulse_out
);
	reg [23:0] count;
	reg phase;
	always @(posedge clk_in) begin
		if (rst_in || !idle_in) begin
			count <= 24'h000000;
			phase <= 1'b0;
			full_speed_out <= 1'b0;
			suspend_pulse_out <= 1'b0;
		end else begin
			suspend_pulse_out <= 1'b0;
			if (!phase) begin
				if (count == FS_CYCLES - 1) begin
					full_speed_out <= 1'b1;
					phase <= 1'b1;
					count <= 24'h000000;
				end else
					count <= count + 24'h000001;
			end else if (count == SUSP_CYCLES - 1) begin
				suspend_pulse_out <= 1'b1;
				count <= count + 24'h000001;
			end else if (count < SUSP_CYCLES - 1)
				count <= count + 24'h000001;
		end
	end
endmodule // idle_timer
`default_nettype wire

// ===== verification/sie_event_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// Event and flag checks
module sie_event_monitor (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [15:0] addr_in,
	input wire logic wr_in,
	input wire logic [7:0] wdata_in,
	input wire logic core_reset_in,
	input wire logic [7:0] bus_event_mask_in,
	input wire logic top_status_0_out,
	input wire logic halt_clear_req_in,
	input wire logic set_config_req_in,
	input wire logic interface_set_flag_req_in,
	input wire logic setup_in,
	input wire logic [7:0] source_irq_out,
	input wire logic ep0_disable_out,
	input wire logic ctrl_out_buffer_flush_out,
	input wire logic ctrl_in_buffer_flush_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	wire logic clr6 = wr_in && addr_in == 16'h2C0A && wdata_in[6];
	a_setup_set: assert property (setup_in && !source_irq_out[2] |=> source_irq_out[2]) else $error("setup flag");
	a_setup_again: assert property (setup_in && source_irq_out[2] |=> !source_irq_out[2] ##1 source_irq_out[2]) else $error("repeat setup");
	a_setup_flush: assert property (setup_in |=> ctrl_out_buffer_flush_out && ctrl_in_buffer_flush_out && ep0_disable_out) else $error("flush");
	a_halt_set: assert property (halt_clear_req_in |=> source_irq_out[6]) else $error("halt flag");
	a_config_set: assert property (set_config_req_in |=> source_irq_out[5]) else $error("config flag");
	a_intf_set: assert property (interface_set_flag_req_in |=> source_irq_out[3]) else $error("interface flag");
	a_reset_after: assert property ($fell(core_reset_in) ##2 bus_event_mask_in[0] |-> top_status_0_out) else $error("bus reset");
	a_mask_gate: assert property (!bus_event_mask_in[0] |-> !top_status_0_out) else $error("mask");
	a_flag_holds: assert property (source_irq_out[6] && !clr6 |=> source_irq_out[6]) else $error("flag lost");
endmodule // sie_event_monitor
bind usb_sie_event_status sie_event_monitor mon (.*);
`default_nettype wire

// ===== verification/usb_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// Bus host requests
module usb_host_model (
	input wire logic clk_in,
	output logic [4:0] req_out,
	output logic [3:0] conf_val_out,
	output logic idle_out
);
	initial begin
		req_out = 5'h00;
		conf_val_out = 4'h0;
		idle_out = 1'b0;
	end
	// Bit 4 is the bus reset level; the value bus is not held past its pulse
	task automatic pulse(input int k, input int n, input logic [3:0] v);
		@(posedge clk_in);
		req_out <= 5'h01 << k;
		conf_val_out <= v;
		repeat (n) @(posedge clk_in);
		req_out <= 5'h00;
		conf_val_out <= ~v;
	endtask
	// Bus idle level, changed on a clock edge only
	task automatic set_idle(input logic v);
		@(posedge clk_in);
		idle_out <= v;
	endtask
endmodule // usb_host_model
`default_nettype wire

// ===== verification/test_usb_sie_event_status.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g,e) begin comparisons++; if ((g)!==(e)) begin failures++; $display("BAD t=%0t got %h exp %h",$time,g,e); end end
module test_usb_sie_event_status;
	// ====================
	// Signals
	logic clk_in=0, rst_in=1, wr_in=0, buf_last_in=0;
	logic [15:0] addr_in=16'h0000, buf_len_in=16'h0000;
	logic [7:0] wdata_in=8'h00, bus_event_mask_in=8'h01, rdata_out, source_irq_out, ep_irq_out;
	logic [3:0] ep_out_event_in=4'h0, ep_in_event_in=4'h0;
	logic [4:0] fifo_level_in=5'h00;
	logic [1:0] endpoint_flush_flag_out;
	logic top_status_0_out, full_speed_out, prefetch_go_out;
	logic ep0_disable_out, ctrl_out_buffer_flush_out, ctrl_in_buffer_flush_out;
	wire logic setup_in, halt_clear_req_in, set_config_req_in, interface_set_flag_req_in, core_reset_in, bus_idle_in;
	wire logic [3:0] config_value_in;
	int failures=0, comparisons=0, n;
	typedef struct packed {logic [4:0] lv; logic last; logic [15:0] len; logic go;} row_t;
	row_t rows[6] = '{{5'h03,1'b0,16'h0000,1'b0}, {5'h04,1'b0,16'h0000,1'b1}, {5'h10,1'b0,16'h0000,1'b1},
		{5'h00,1'b1,16'h0004,1'b1}, {5'h03,1'b0,16'h0004,1'b0}, {5'h00,1'b1,16'h0028,1'b0}};
	// Short idle counts keep the run brief
	usb_sie_event_status #(.FS_CYCLES(10), .SUSP_CYCLES(5)) dut (.*);
	usb_host_model host (.clk_in(clk_in), .conf_val_out(config_value_in), .idle_out(bus_idle_in),
		.req_out({core_reset_in,interface_set_flag_req_in,set_config_req_in,halt_clear_req_in,setup_in}));
	initial begin
		forever #10 clk_in = ~clk_in;
	end
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [7:0] e);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= w;
		@(posedge clk_in);
		wr_in <= 1'b0;
		@(posedge clk_in);
		#1;
		if (!w) `CHK(rdata_out, e)
	endtask
	task automatic final_report;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ====================
	// Sequence
	initial begin
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		foreach (rows[i]) begin
			@(posedge clk_in);
			{fifo_level_in, buf_last_in, buf_len_in} <= rows[i][22:1];
			@(posedge clk_in);
			#1 `CHK(prefetch_go_out, rows[i].go)
		end
		$display("prefetch table done");
		acc(0, 16'h2C03, 8'h00, 8'h03);
		acc(1, 16'h2C03, 8'hF5, 8'h00);
		acc(0, 16'h2C03, 8'h00, 8'h05);
		acc(0, 16'h2C07, 8'h00, 8'h00);
		acc(1, 16'h2C0C, 8'hFF, 8'h00);
		acc(0, 16'h2C0C, 8'h00, 8'h00);
		$display("register access done");
		host.pulse(4, 3, 4'h0);
		repeat (3) @(posedge clk_in);
		`CHK(top_status_0_out, 1'b1)
		acc(1, 16'h2C08, 8'h00, 8'h00);
		acc(0, 16'h2C08, 8'h00, 8'h01);
		acc(1, 16'h2C08, 8'h01, 8'h00);
		acc(0, 16'h2C08, 8'h00, 8'h00);
		$display("bus reset done");
		for (int k = 0; k < 4; k++) host.pulse(k, 1, 4'h9);
		acc(0, 16'h2C0A, 8'h00, 8'h6C);
		acc(0, 16'h2C01, 8'h00, 8'h09);
		`CHK(endpoint_flush_flag_out, 2'h3)
		host.pulse(0, 1, 4'h0);
		acc(1, 16'h2C0A, 8'h6C, 8'h00);
		acc(0, 16'h2C0A, 8'h00, 8'h00);
		$display("source events done");
		host.set_idle(1'b1);
		for (n = 0; n < 40 && source_irq_out[4] !== 1'b1; n++) begin
			@(posedge clk_in);
			#1;
		end
		`CHK(full_speed_out, 1'b1)
		`CHK(n, 16)
		@(posedge clk_in);
		ep_out_event_in <= 4'h8;
		ep_in_event_in <= 4'h1;
		bus_event_mask_in <= 8'h00;
		@(posedge clk_in);
		#1 `CHK(ep_irq_out, 8'h81)
		$display("suspend and endpoint done");
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		acc(0, 16'h2C03, 8'h00, 8'h03);
		acc(0, 16'h2C0A, 8'h00, 8'h00);
		$display("mid-run reset done");
		final_report();
	end
endmodule // test_usb_sie_event_status
`default_nettype wire
